/* File: shared/crp_params.svh */
// Offsets, field positions, reset values and timing counts of the readout port
`ifndef CRP_PARAMS_SVH
`define CRP_PARAMS_SVH

// Device register addresses (14-bit)
`define CRP_CTRL_ADDR   14'h0010
`define CRP_CHEN_ADDR   14'h0011
`define CRP_STAT_ADDR   14'h0012
`define CRP_PERCH_ADDR  14'h0020
`define CRP_R24_ADDR    14'h0030
`define CRP_R24S_ADDR   14'h0031
`define CRP_R16_ADDR    14'h0032
`define CRP_R16S_ADDR   14'h0033

// Control and channel-enable register fields
`define CRP_CTRL_STRM   0
`define CRP_CTRL_FLAGS  2
`define CRP_CTRL_SHARED 3
`define CRP_CTRL_MODE   4
`define CRP_CTRL_CRC    7
`define CRP_CHEN_AUX    4

// Reset values and encodings
`define CRP_CTRL_RST    8'h00
`define CRP_CHEN_RST    8'h01
`define CRP_MODE_CONT   3'h0
`define CRP_MODE_FIR    3'h1
`define CRP_MODE_ONCE   3'h4
`define CRP_STRM_ON     2'h1
`define CRP_EXIT_CMD    8'hA5
`define CRP_CRC_SEED    8'hA5
`define CRP_CRC_POLY    8'h07
`define CRP_DATA_BITS   6'h18
`define CRP_BYTE_BITS   6'h08
`define CRP_RST_ONES    7'h3F
`define CRP_RST_REPS    2'h3

// Host command port
`define CRP_H_CMD       4'h0
`define CRP_H_TGT       4'h1
`define CRP_H_WBYTE     4'h2
`define CRP_H_CFG       4'h3
`define CRP_H_RXLO      4'h4
`define CRP_H_RXHI      4'h5
`define CRP_H_STAT      4'h6
`define CRP_H_CFG_RST   7'h18
`define CRP_OP_WRITE    3'h1
`define CRP_OP_READ     3'h2
`define CRP_OP_STREAM   3'h3
`define CRP_OP_EXIT     3'h4
`define CRP_OP_RESET    3'h5
`define CRP_RST_BITS    8'hC0

// Timing
`define CRP_CLK_NS      100
`define CRP_SCLK_NS     800
`define CRP_HALF_CYC    (`CRP_SCLK_NS / 2 / `CRP_CLK_NS)

`endif

/* File: shared/crp_pkg.sv */
// State types of the two ends of the readout port, one for each end
package crp_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_INS  = 6'h02,
    ST_WR   = 6'h04,
    ST_RD   = 6'h08,
    ST_STRM = 6'h10,
    ST_HOLD = 6'h20
  } crp_dst_e;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_WAIT = 5'h02,
    H_HIGH = 5'h04,
    H_LOW  = 5'h08,
    H_END  = 5'h10
  } crp_hst_e;
endpackage

/* File: shared/crp_link_if.sv */
// Four-wire serial link plus auxiliary ready pin
`timescale 1ns/10ps
interface crp_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;
  logic aux_rdy_n;

  // Pulled high when the device leaves the line undriven
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (input cs_n, input sclk, input sdi,
               output sdo, output sdo_oe, output aux_rdy_n);
  modport hst (output cs_n, output sclk, output sdi,
               input sdo_line, input aux_rdy_n);
endinterface

/* File: design/crp_dev.sv */
// Device end of the conversion readout port
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "crp_params.svh"
module crp_dev
  import crp_pkg::*;
#(
  parameter int N_CHAN = 4
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Serial link
  crp_link_if.dev          LNK,
  // Converter side
  input  wire logic        CONV_DONE,
  input  wire logic [23:0] CONV_DATA,
  output logic      [1:0]  CONV_CHAN,
  output logic             CONV_RUN
);
  if (N_CHAN < 1 || N_CHAN > 4) begin : g_chk
    $error("N_CHAN must lie between 1 and 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic        sclk_d;
  logic [7:0]  ctrl;
  logic [7:0]  chen;
  logic        restart;
  logic [23:0] res [4];
  logic [23:0] shr;
  logic [1:0]  shr_ch;
  logic        rdy_n;
  logic [3:0]  unread;
  logic [3:0]  next_unread;
  logic        upd_d;
  logic        soft_rst;
  logic [6:0]  ones;
  logic [1:0]  reps;
  crp_dst_e    st;
  logic [5:0]  cnt;
  logic [5:0]  slen_q;
  logic [15:0] rx;
  logic [39:0] sr;
  logic        shown;
  logic        exit_req;
  logic [13:0] addr;
  logic [7:0]  wr_data;
  logic        wr_ev;
  logic        rd_ev;
  logic        done_ev;
  logic [39:0] rview;
  logic [39:0] sword;
  logic [5:0]  slen;
  logic [7:0]  crc;
  logic        sdo_bit;
  logic        sdo_en;
  logic        aux_rdy;

  // Input sync order: {cs_n, sclk, sdi}
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1  <= 3'h6;
      sync2  <= 3'h6;
      sclk_d <= 1'b1;
    end else begin
      sync1  <= {LNK.cs_n, LNK.sclk, LNK.sdi};
      sync2  <= sync1;
      sclk_d <= sync2[1];
    end
  end

  wire cs_n  = sync2[2];
  wire sdi_s = sync2[0];
  wire rise  = sync2[1] && !sclk_d;
  wire fall  = !sync2[1] && sclk_d;
  wire rst   = !RST_N || soft_rst;

  wire [3:0] en     = chen[3:0] & 4'((1 << N_CHAN) - 1);
  wire       shared = ctrl[`CRP_CTRL_SHARED];
  wire       strm   = shared && ctrl[`CRP_CTRL_STRM +: 2] == `CRP_STRM_ON;
  wire [2:0] mode   = ctrl[`CRP_CTRL_MODE +: 3];
  wire       flags  = ctrl[`CRP_CTRL_FLAGS];
  wire       crc_en = ctrl[`CRP_CTRL_CRC];
  wire       aux    = chen[`CRP_CHEN_AUX];
  wire [7:0] status = {rdy_n, CONV_RUN, 4'h0, shr_ch};

  function automatic logic [1:0] first_en(input logic [3:0] e);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (e[i])
        r = 2'(i);
    return r;
  endfunction

  // Returns {wrapped, channel}
  function automatic logic [2:0] next_en(input logic [3:0] e, input logic [1:0] c);
    logic [2:0] r;
    r = {1'b1, first_en(e)};
    for (int i = 3; i >= 0; i--)
      if (e[i] && i > int'(c))
        r = {1'b0, 2'(i)};
    return r;
  endfunction

  function automatic logic [7:0] crc8(input logic [31:0] d, input logic four);
    logic [7:0] c;
    c = `CRP_CRC_SEED;
    for (int i = 31; i >= 0; i--)
      if (four || i < 24)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRP_CRC_POLY : 8'h00);
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register map and sequencer
  always_ff @(posedge CLK) begin
    if (rst) begin
      ctrl    <= `CRP_CTRL_RST;
      chen    <= `CRP_CHEN_RST;
      restart <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (wr_ev) begin
        restart <= 1'b1;
        if (addr == `CRP_CTRL_ADDR)
          ctrl <= wr_data;
        else if (addr == `CRP_CHEN_ADDR)
          chen <= wr_data;
      end else if (done_ev && exit_req) begin
        ctrl[`CRP_CTRL_STRM +: 2] <= 2'h0;
      end
    end
  end

  wire [2:0] nxt = next_en(en, CONV_CHAN);
  wire       fir = mode == `CRP_MODE_FIR;
  wire       wrap = fir || nxt[2];

  // Restart follows a write by one cycle so it sees the new settings
  always_ff @(posedge CLK) begin
    if (rst) begin
      CONV_CHAN <= 2'h0;
      CONV_RUN  <= 1'b1;
    end else if (restart) begin
      CONV_CHAN <= first_en(en);
      CONV_RUN  <= 1'b1;
    end else if (CONV_DONE && CONV_RUN) begin
      if (fir)
        CONV_CHAN <= first_en(en);
      else
        CONV_CHAN <= nxt[1:0];
      if (mode == `CRP_MODE_ONCE && nxt[2])
        CONV_RUN <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results and ready
  wire sh_addr  = addr >= `CRP_R24_ADDR && addr <= `CRP_R16S_ADDR;
  wire ch_addr  = addr[13:2] == `CRP_PERCH_ADDR >> 2;
  wire busy_sh  = st == ST_RD && sh_addr;
  wire busy_ch  = st == ST_RD && ch_addr && addr[1:0] == CONV_CHAN;
  wire upd      = CONV_DONE && CONV_RUN && (shared ? !busy_sh : !busy_ch);
  wire rd_sh_ev = rd_ev && sh_addr;
  wire rd_ch_ev = rd_ev && ch_addr;

  always_ff @(posedge CLK) begin
    if (rst) begin
      shr    <= 24'h000000;
      shr_ch <= 2'h0;
      upd_d  <= 1'b0;
      for (int i = 0; i < 4; i++)
        res[i] <= 24'h000000;
    end else begin
      upd_d <= upd && shared;
      if (upd && shared) begin
        shr    <= CONV_DATA;
        shr_ch <= CONV_CHAN;
      end else if (upd) begin
        res[CONV_CHAN] <= CONV_DATA;
      end
    end
  end

  always_comb begin
    next_unread = unread;
    if (rd_ch_ev)
      next_unread[addr[1:0]] = 1'b0;
    if (upd && !shared)
      next_unread[CONV_CHAN] = 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (rst)
      unread <= 4'h0;
    else
      unread <= next_unread;
  end

  // A completing conversion wins over a read that clears ready
  always_ff @(posedge CLK) begin
    if (rst)
      rdy_n <= 1'b1;
    else if (upd && (shared || wrap))
      rdy_n <= 1'b0;
    else if (shared ? (rd_sh_ev || done_ev) : (rd_ch_ev && next_unread == 4'h0))
      rdy_n <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pattern detector: runs on every rising serial clock while selected
  always_ff @(posedge CLK) begin
    if (rst) begin
      ones     <= 7'h00;
      reps     <= 2'h0;
      soft_rst <= 1'b0;
    end else if (rise && !cs_n) begin
      if (sdi_s) begin
        ones <= (ones > `CRP_RST_ONES) ? ones : ones + 7'h01;
      end else begin
        ones <= 7'h00;
        if (ones == `CRP_RST_ONES) begin
          reps     <= reps + 2'h1;
          soft_rst <= reps == `CRP_RST_REPS - 2'h1;
        end else begin
          reps <= 2'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout words
  wire [13:0] vaddr = (st == ST_INS) ? {rx[12:0], sdi_s} : addr;

  always_comb begin
    rview = 40'h0000000000;
    if (vaddr == `CRP_CTRL_ADDR)
      rview[39:32] = ctrl;
    else if (vaddr == `CRP_CHEN_ADDR)
      rview[39:32] = chen;
    else if (vaddr == `CRP_STAT_ADDR)
      rview[39:32] = status;
    else if (vaddr == `CRP_R24_ADDR)
      rview[39:16] = shr;
    else if (vaddr == `CRP_R24S_ADDR)
      rview[39:8] = {shr, status};
    else if (vaddr == `CRP_R16_ADDR)
      rview[39:24] = shr[23:8];
    else if (vaddr == `CRP_R16S_ADDR)
      rview[39:16] = {shr[23:8], status};
    else if (vaddr[13:2] == `CRP_PERCH_ADDR >> 2)
      rview[39:16] = res[vaddr[1:0]];
  end

  always_comb begin
    crc   = crc8(flags ? {shr, status} : {8'h00, shr}, flags);
    sword = {shr, 16'h0000};
    slen  = `CRP_DATA_BITS;
    if (flags) begin
      sword[15:8] = status;
      slen        = slen + `CRP_BYTE_BITS;
    end
    if (crc_en) begin
      if (flags)
        sword[7:0] = crc;
      else
        sword[15:8] = crc;
      slen = slen + `CRP_BYTE_BITS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial state machine
  wire ld = strm && ((st == ST_IDLE) ? !rdy_n : ((st == ST_STRM || st == ST_HOLD) && upd_d));

  always_ff @(posedge CLK) begin
    wr_ev   <= 1'b0;
    rd_ev   <= 1'b0;
    done_ev <= 1'b0;
    if (rst) begin
      st       <= ST_IDLE;
      cnt      <= 6'h00;
      slen_q   <= `CRP_DATA_BITS;
      rx       <= 16'h0000;
      sr       <= 40'h0000000000;
      shown    <= 1'b0;
      exit_req <= 1'b0;
      addr     <= 14'h0000;
      wr_data  <= 8'h00;
    end else if (cs_n) begin
      st    <= ST_IDLE;
      cnt   <= 6'h00;
      shown <= 1'b0;
    end else if (ld) begin
      st       <= ST_STRM;
      sr       <= sword;
      slen_q   <= slen;
      cnt      <= 6'h00;
      shown    <= 1'b0;
      exit_req <= 1'b0;
    end else begin
      if (st == ST_HOLD && !strm)
        st <= ST_IDLE;
      // Falling edge: first one exposes the MSB, later ones shift
      if (fall && (st == ST_RD || st == ST_STRM)) begin
        if (shown)
          sr <= {sr[38:0], 1'b0};
        shown <= 1'b1;
      end
      if (rise) begin
        rx  <= {rx[14:0], sdi_s};
        cnt <= cnt + 6'h01;
        case (st)
          ST_IDLE: begin
            if (!strm && !sdi_s) begin
              st  <= ST_INS;
              cnt <= 6'h01;
            end
          end
          ST_INS: begin
            if (cnt == 6'h0F) begin
              addr <= {rx[12:0], sdi_s};
              cnt  <= 6'h00;
              if (rx[13]) begin
                st    <= ST_RD;
                sr    <= rview;
                shown <= 1'b0;
                rd_ev <= 1'b1;
              end else begin
                st <= ST_WR;
              end
            end
          end
          ST_WR: begin
            if (cnt == 6'h07) begin
              wr_ev   <= 1'b1;
              wr_data <= {rx[6:0], sdi_s};
              st      <= ST_IDLE;
            end
          end
          ST_STRM: begin
            if (cnt == 6'h07 && {rx[6:0], sdi_s} == `CRP_EXIT_CMD)
              exit_req <= 1'b1;
            if (cnt == slen_q - 6'h01) begin
              st      <= ST_HOLD;
              done_ev <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered
  always_ff @(posedge CLK) begin
    if (rst) begin
      sdo_bit <= 1'b1;
      sdo_en  <= 1'b0;
      aux_rdy <= 1'b1;
    end else begin
      sdo_en  <= !cs_n;
      aux_rdy <= aux ? rdy_n : 1'b1;
      case (st)
        ST_RD:   sdo_bit <= sr[39];
        ST_STRM: sdo_bit <= (shown || aux) ? sr[39] : rdy_n;
        ST_HOLD: sdo_bit <= aux ? sr[39] : rdy_n;
        ST_IDLE: sdo_bit <= aux ? 1'b1 : rdy_n;
        default: sdo_bit <= 1'b0;
      endcase
    end
  end

  assign LNK.sdo       = sdo_bit;
  assign LNK.sdo_oe    = sdo_en;
  assign LNK.aux_rdy_n = aux_rdy;
endmodule

/* File: design/crp_host.sv */
// Host end of the conversion readout port: serial master with command registers
`timescale 1ns/10ps
`include "crp_params.svh"
module crp_host
  import crp_pkg::*;
#(
  parameter int HALF_CYC = `CRP_HALF_CYC
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Serial link
  crp_link_if.hst          LNK,
  // Command port
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA
);
  // Below four cycles the device cannot turn its output round in time
  if (HALF_CYC < 4 || HALF_CYC > 256) begin : g_chk
    $error("HALF_CYC must lie between 4 and 256");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]  sync1;
  logic [1:0]  sync2;
  logic [13:0] tgt;
  logic [7:0]  wbyte;
  logic [5:0]  len;
  logic        aux_sel;
  logic [39:0] rxd;
  crp_hst_e    st;
  logic [7:0]  hcnt;
  logic [7:0]  bitn;
  logic [7:0]  nbits;
  logic [63:0] tx;
  logic        rpat;
  logic        cs_n;
  logic        sclk;
  logic        sdi;

  // Input sync order: {sdo line, aux ready}
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
    end else begin
      sync1 <= {LNK.sdo_line, LNK.aux_rdy_n};
      sync2 <= sync1;
    end
  end

  wire rdy_seen = !cs_n && (aux_sel ? !sync2[0] : !sync2[1]);
  wire half_end = hcnt == 8'(HALF_CYC - 1);
  wire start    = WR && ADDR == `CRP_H_CMD && st == H_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Command registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tgt     <= 14'h0000;
      wbyte   <= 8'h00;
      {aux_sel, len} <= `CRP_H_CFG_RST;
    end else if (WR) begin
      if (ADDR == `CRP_H_TGT)
        tgt <= WDATA[13:0];
      else if (ADDR == `CRP_H_WBYTE)
        wbyte <= WDATA[7:0];
      else if (ADDR == `CRP_H_CFG)
        {aux_sel, len} <= WDATA[6:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N)
      RDATA <= 32'h00000000;
    else if (!RD)
      RDATA <= 32'h00000000;
    else if (ADDR == `CRP_H_TGT)
      RDATA <= {18'h00000, tgt};
    else if (ADDR == `CRP_H_WBYTE)
      RDATA <= {24'h000000, wbyte};
    else if (ADDR == `CRP_H_CFG)
      RDATA <= {25'h0000000, aux_sel, len};
    else if (ADDR == `CRP_H_RXLO)
      RDATA <= rxd[31:0];
    else if (ADDR == `CRP_H_RXHI)
      RDATA <= {24'h000000, rxd[39:32]};
    else if (ADDR == `CRP_H_STAT)
      RDATA <= {30'h00000000, rdy_seen, st != H_IDLE};
    else
      RDATA <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine: clock idles high, data changes on the falling edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st    <= H_IDLE;
      hcnt  <= 8'h00;
      bitn  <= 8'h00;
      nbits <= 8'h00;
      tx    <= 64'h0000000000000000;
      rpat  <= 1'b0;
      rxd   <= 40'h0000000000;
      cs_n  <= 1'b1;
      sclk  <= 1'b1;
      sdi   <= 1'b1;
    end else begin
      hcnt <= half_end ? 8'h00 : hcnt + 8'h01;
      case (st)
        H_IDLE: begin
          hcnt <= 8'h00;
          if (start && WDATA[2:0] >= `CRP_OP_WRITE && WDATA[2:0] <= `CRP_OP_RESET) begin
            cs_n <= 1'b0;
            sdi  <= 1'b0;
            bitn <= 8'h00;
            rpat <= WDATA[2:0] == `CRP_OP_RESET;
            st   <= H_HIGH;
            tx   <= 64'h0000000000000000;
            case (WDATA[2:0])
              `CRP_OP_WRITE: begin
                tx    <= {2'b00, tgt, wbyte, 40'h0000000000};
                nbits <= 8'h18;
              end
              `CRP_OP_READ: begin
                tx    <= {2'b01, tgt, 48'h000000000000};
                nbits <= 8'h30;
              end
              `CRP_OP_STREAM: begin
                nbits <= {2'b00, len};
                st    <= H_WAIT;
              end
              `CRP_OP_EXIT: begin
                tx    <= {`CRP_EXIT_CMD, 56'h00000000000000};
                nbits <= {2'b00, len};
                st    <= H_WAIT;
              end
              default: begin
                nbits <= `CRP_RST_BITS;
              end
            endcase
          end
        end
        H_WAIT: begin
          hcnt <= 8'h00;
          if (rdy_seen)
            st <= H_HIGH;
        end
        H_HIGH: begin
          if (half_end) begin
            // Sample late in the high phase: covers device turn-round
            if (bitn != 8'h00)
              rxd <= {rxd[38:0], sync2[1]};
            if (bitn == nbits) begin
              st   <= H_END;
              cs_n <= 1'b1;
              sdi  <= 1'b1;
            end else begin
              st   <= H_LOW;
              sclk <= 1'b0;
              sdi  <= rpat ? bitn[5:0] != 6'h3F : tx[63];
              tx   <= {tx[62:0], 1'b0};
              bitn <= bitn + 8'h01;
            end
          end
        end
        H_LOW: begin
          if (half_end) begin
            st   <= H_HIGH;
            sclk <= 1'b1;
          end
        end
        H_END: begin
          if (half_end)
            st <= H_IDLE;
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  assign LNK.cs_n = cs_n;
  assign LNK.sclk = sclk;
  assign LNK.sdi  = sdi;
endmodule

/* File: sim/crp_link_assertions.sv */
// Checker on the link between the host and device ends
`timescale 1ns/10ps
module crp_link_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_line,
  input wire logic aux_rdy_n
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] rises;
  // Rising serial clocks seen in the open frame
  always_ff @(posedge CLK) begin
    if (!RST_N || cs_n) rises <= 8'h00;
    else if ($rose(sclk)) rises <= rises + 8'h01;
  end
  property p_rst;
    $rose(RST_N) |-> cs_n && sclk && sdi && !sdo_oe && aux_rdy_n;
  endproperty
  a_rst: assert property (p_rst) else $error("link busy after reset");
  property p_float;
    cs_n [*5] |-> !sdo_oe;
  endproperty
  a_float: assert property (p_float) else $error("output driven while deselected");
  property p_drive;
    $fell(cs_n) |-> ##[1:6] sdo_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("output not driven");
  property p_idle;
    cs_n |-> sclk && sdi;
  endproperty
  a_idle: assert property (p_idle) else $error("idle lines not high");
  property p_frame;
    $fell(sclk) |-> !cs_n;
  endproperty
  a_frame: assert property (p_frame) else $error("clock outside frame");
  property p_low;
    $fell(sclk) |=> !sclk [*3];
  endproperty
  a_low: assert property (p_low) else $error("short low phase");
  property p_sdi;
    $changed(sdi) && !cs_n && !$fell(cs_n) |-> $fell(sclk);
  endproperty
  a_sdi: assert property (p_sdi) else $error("data moved off falling clock");
  property p_bits;
    $rose(cs_n) |-> rises inside {8'h18, 8'h30, 8'hC0};
  endproperty
  a_bits: assert property (p_bits) else $error("bad frame length");
endmodule

/* File: sim/crp_test.sv */
// Bench joining both ends, with a converter stand-in
`timescale 1ns/10ps
module crp_test;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        CONV_DONE = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic [23:0] CONV_DATA = 24'h0;
  logic [31:0] RDATA;
  logic [1:0]  CONV_CHAN;
  logic        CONV_RUN;
  logic [31:0] r;
  logic [23:0] d;
  int          error_cnt = 0;
  int          checks_done = 0;
  crp_link_if i_crp_link_if ();
  crp_dev i_crp_dev (.CLK(CLK), .RST_N(RST_N), .LNK(i_crp_link_if.dev), .CONV_DONE(CONV_DONE),
    .CONV_DATA(CONV_DATA), .CONV_CHAN(CONV_CHAN), .CONV_RUN(CONV_RUN));
  crp_host i_crp_host (.CLK(CLK), .RST_N(RST_N), .LNK(i_crp_link_if.hst), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  crp_link_assertions i_chk (.CLK(CLK), .RST_N(RST_N), .cs_n(i_crp_link_if.cs_n),
    .sclk(i_crp_link_if.sclk), .sdi(i_crp_link_if.sdi), .sdo(i_crp_link_if.sdo),
    .sdo_oe(i_crp_link_if.sdo_oe), .sdo_line(i_crp_link_if.sdo_line),
    .aux_rdy_n(i_crp_link_if.aux_rdy_n));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Expected shared result view: words are left-aligned, zero filled
  function automatic logic [31:0] view(input logic [23:0] v, input logic half);
    return half ? {v[23:8], 16'h0000} : {v, 8'h00};
  endfunction
  task automatic hw(input logic [3:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a, output logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    v = RDATA;
  endtask
  // Issue a host command and poll busy; bounded so a stuck host cannot hang
  task automatic op(input logic [2:0] c);
    int n;
    hw(4'h0, {29'h0, c});
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 3000) begin
      hr(4'h6, r);
      n++;
    end
    // A host still busy at the limit is a hang and counts as a mismatch
    chk({31'h0, r[0]}, 32'h0);
  endtask
  task automatic dw(input logic [13:0] a, input logic [7:0] v);
    hw(4'h1, {18'h0, a});
    hw(4'h2, {24'h0, v});
    op(3'h1);
  endtask
  task automatic dr(input logic [13:0] a, input logic [31:0] e);
    hw(4'h1, {18'h0, a});
    op(3'h2);
    hr(4'h4, r);
    chk(r, e);
  endtask
  task automatic conv(input logic [23:0] v);
    @(posedge CLK);
    CONV_DONE <= 1'b1;
    CONV_DATA <= v;
    @(posedge CLK);
    CONV_DONE <= 1'b0;
    repeat (4) @(negedge CLK);
  endtask
  // Streaming read of a fresh result, 24 bits back
  task automatic strm(input logic [2:0] c, input logic [23:0] v);
    conv(v);
    op(c);
    hr(4'h4, r);
    chk({8'h00, r[23:0]}, {8'h00, v});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 CLK = ~CLK;
  end
  initial begin
    repeat (60000) @(posedge CLK);
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(19262));
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    hr(4'h7, r);
    chk(r, 32'h0);
    dr(14'h0010, 32'h0);
    dr(14'h0011, 32'h01000000);
    // Per-channel results on channels 1 and 3, ready shown on the aux pin
    dw(14'h0011, 8'h1A);
    d = 24'($urandom);
    conv(d);
    conv(24'h5A5A5A);
    chk({31'h0, i_crp_link_if.aux_rdy_n}, 32'h0);
    dr(14'h0012, 32'h40000000);
    dr(14'h0021, {d, 8'h00});
    chk({31'h0, i_crp_link_if.aux_rdy_n}, 32'h0);
    dr(14'h0023, 32'h5A5A5A00);
    chk({31'h0, i_crp_link_if.aux_rdy_n}, 32'h1);
    dr(14'h0012, 32'hC0000000);
    dw(14'h0010, 8'h08);
    dw(14'h0011, 8'h0A);
    conv(24'h000000);
    for (int i = 0; i < 4; i++) begin
      chk({30'h0, CONV_CHAN}, i[0] ? 32'h1 : 32'h3);
      conv(24'($urandom));
    end
    d = 24'($urandom);
    conv(d);
    dr(14'h0030, view(d, 1'b0));
    d = 24'h800001;
    conv(d);
    dr(14'h0032, view(d, 1'b1));
    dw(14'h0010, 8'h18);
    repeat (2) begin
      conv(24'($urandom));
      chk({30'h0, CONV_CHAN}, 32'h1);
    end
    dw(14'h0010, 8'h09);
    strm(3'h3, 24'($urandom));
    strm(3'h4, 24'hFFFFFF);
    dr(14'h0010, 32'h08000000);
    dw(14'h0010, 8'h48);
    repeat (3) conv(24'($urandom));
    chk({31'h0, CONV_RUN}, 32'h0);
    op(3'h5);
    dr(14'h0010, 32'h0);
    chk({31'h0, CONV_RUN}, 32'h1);
    stop_test();
  end
endmodule
